// file: inc/cce_pkg.sv
package cce_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] CCE_T1_ENPOL_ADDR  = 32'h4000_E020;
    localparam logic [31:0] CCE_T2_ENPOL_ADDR  = 32'h4000_F020;
    localparam logic [31:0] CCE_TIM1_MODE_ADDR = 32'h4000_E0F0;
    localparam logic [31:0] CCE_TIM2_MODE_ADDR = 32'h4000_F0F0;
    localparam logic [31:0] CCE_CCER_MASK      = 32'h0000_3333;
    localparam logic [31:0] CCE_MODE_MASK      = 32'h0000_FFFF;
    localparam logic [31:0] CCE_CCER_RESET     = 32'h0000_0000;
    localparam logic [31:0] CCE_MODE_RESET     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field layout, one nibble per channel in both registers
    // ------------------------------------------------------------
    localparam int CCE_CH_STRIDE = 4;
    localparam int CCE_EN_BIT    = 0;
    localparam int CCE_POL_BIT   = 1;
    localparam int CCE_SEL_LSB   = 0;
    localparam int CCE_DIV_LSB   = 2;

    // Decode result bit positions
    localparam int CCE_DEC_VALID = 2;
    localparam int CCE_DEC_MODE  = 1;
    localparam int CCE_DEC_TIMER = 0;

    typedef enum logic [1:0] {
        CCE_SEL_OUT  = 2'b00,
        CCE_SEL_OWN  = 2'b01,
        CCE_SEL_PAIR = 2'b10,
        CCE_SEL_TRIG = 2'b11
    } cce_sel_e;

    // Edges to skip before a capture: 0, 1, 3, 7
    function automatic logic [2:0] cce_div_limit(input logic [1:0] div);
        cce_div_limit = 3'((4'h1 << div) - 4'h1);
    endfunction

    // {valid, mode register, timer 2}
    function automatic logic [2:0] cce_decode(input logic [31:0] addr);
        case (addr)
            CCE_T1_ENPOL_ADDR:  cce_decode = 3'b100;
            CCE_T2_ENPOL_ADDR:  cce_decode = 3'b101;
            CCE_TIM1_MODE_ADDR: cce_decode = 3'b110;
            CCE_TIM2_MODE_ADDR: cce_decode = 3'b111;
            default:            cce_decode = 3'b000;
        endcase
    endfunction

endpackage

// file: verilog/cce_chan.sv
`timescale 1ns/1ps
`default_nettype none

module cce_chan
    import cce_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       polarity,
    input  wire logic       enable,
    input  wire logic [1:0] dir_sel,
    input  wire logic [1:0] cap_div,
    input  wire logic       oc_ref,
    input  wire logic       in_own,
    input  wire logic       in_pair,
    input  wire logic       trig_in,
    output logic            compare_out,
    output logic            compare_oe,
    output logic            capture,
    output logic            trig_sensed
);

    logic       is_input;
    logic       raw;
    logic       sensed;
    logic       edge_seen;
    logic       prev_r,  prev_nxt;
    logic [2:0] cnt_r,   cnt_nxt;
    logic       cap_r,   cap_nxt;
    logic       out_r,   out_nxt;
    logic       oe_r,    oe_nxt;
    logic       trig_r,  trig_nxt;

    always_comb
    begin
        is_input = (cce_sel_e'(dir_sel) != CCE_SEL_OUT);
        case (cce_sel_e'(dir_sel))
            CCE_SEL_OUT:  raw = 1'b0;
            CCE_SEL_OWN:  raw = in_own;
            CCE_SEL_PAIR: raw = in_pair;
            CCE_SEL_TRIG: raw = trig_in;
            default:      raw = 1'b0;
        endcase
        // Inverting the input turns a falling edge into a rising one
        sensed    = raw ^ polarity;
        edge_seen = sensed & ~prev_r;
        prev_nxt  = sensed;
        trig_nxt  = is_input & sensed;
        cnt_nxt   = cnt_r;
        cap_nxt   = 1'b0;
        if (!(is_input && enable))
        begin
            cnt_nxt = 3'h0;
        end
        else if (edge_seen)
        begin
            // >= so a smaller divider written mid-count still fires
            if (cnt_r >= cce_div_limit(cap_div))
            begin
                cnt_nxt = 3'h0;
                cap_nxt = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r + 3'h1;
            end
        end
        oe_nxt  = !is_input && enable;
        out_nxt = oe_nxt ? (oc_ref ^ polarity) : 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev_r <= 1'b0;
            cnt_r  <= 3'h0;
            cap_r  <= 1'b0;
            out_r  <= 1'b0;
            oe_r   <= 1'b0;
            trig_r <= 1'b0;
        end
        else
        begin
            prev_r <= prev_nxt;
            cnt_r  <= cnt_nxt;
            cap_r  <= cap_nxt;
            out_r  <= out_nxt;
            oe_r   <= oe_nxt;
            trig_r <= trig_nxt;
        end
    end

    assign compare_out = out_r;
    assign compare_oe  = oe_r;
    assign capture     = cap_r;
    assign trig_sensed = trig_r;

endmodule

`default_nettype wire

// file: verilog/cce_top.sv
`timescale 1ns/1ps
`default_nettype none

module cce_top
    import cce_pkg::*;
#(
    parameter int NUM_TIMERS = 2,
    parameter int NUM_CH     = 4
)
(
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    input  wire logic [NUM_TIMERS*NUM_CH-1:0] oc_ref,
    input  wire logic [NUM_TIMERS*NUM_CH-1:0] timer_input,
    input  wire logic [NUM_TIMERS-1:0]        internal_trigger_input,
    output logic      [NUM_TIMERS*NUM_CH-1:0] chan_compare_output,
    output logic      [NUM_TIMERS*NUM_CH-1:0] chan_compare_oe,
    output logic      [NUM_TIMERS*NUM_CH-1:0] chan_capture,
    output logic      [NUM_TIMERS*NUM_CH-1:0] chan_trigger_sensed
);

    // ------------------------------------------------------------
    // Bus slave and registers
    // ------------------------------------------------------------
    logic [31:0] ccer_r  [NUM_TIMERS];
    logic [31:0] ccer_nxt[NUM_TIMERS];
    logic [31:0] mode_r  [NUM_TIMERS];
    logic [31:0] mode_nxt[NUM_TIMERS];
    logic        wr_r,    wr_nxt;
    logic        rd_r,    rd_nxt;
    logic [2:0]  tgt_r,   tgt_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        accept;
    logic [2:0]  dec;
    logic [31:0] wval;
    int          t;

    // hsize ignored: only whole-word transfers are issued
    assign accept = hsel && hready && htrans[1];
    assign dec    = cce_decode(haddr);

    always_comb
    begin
        wval = 32'h0000_0000;
        t    = 0;
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
            ccer_nxt[i] = ccer_r[i];
            mode_nxt[i] = mode_r[i];
        end
        if (wr_r && tgt_r[CCE_DEC_VALID])
        begin
            t = int'(tgt_r[CCE_DEC_TIMER]);
            if (!tgt_r[CCE_DEC_MODE])
            begin
                ccer_nxt[t] = hwdata & CCE_CCER_MASK;
            end
            else
            begin
                wval = hwdata & CCE_MODE_MASK;
                // Live channels keep their direction select
                for (int k = 0; k < NUM_CH; k++)
                begin
                    if (ccer_r[t][k*CCE_CH_STRIDE+CCE_EN_BIT])
                    begin
                        wval[k*CCE_CH_STRIDE+CCE_SEL_LSB +: 2] =
                            mode_r[t][k*CCE_CH_STRIDE+CCE_SEL_LSB +: 2];
                    end
                end
                mode_nxt[t] = wval;
            end
        end
        wr_nxt    = accept && hwrite;
        rd_nxt    = accept && !hwrite;
        tgt_nxt   = accept ? dec : 3'b000;
        rdata_nxt = 32'h0000_0000;
        // Read from next values so a write just before is seen
        if (rd_nxt && dec[CCE_DEC_VALID])
        begin
            if (dec[CCE_DEC_MODE])
            begin
                rdata_nxt = mode_nxt[int'(dec[CCE_DEC_TIMER])];
            end
            else
            begin
                rdata_nxt = ccer_nxt[int'(dec[CCE_DEC_TIMER])];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                ccer_r[i] <= CCE_CCER_RESET;
                mode_r[i] <= CCE_MODE_RESET;
            end
            wr_r    <= 1'b0;
            rd_r    <= 1'b0;
            tgt_r   <= 3'b000;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                ccer_r[i] <= ccer_nxt[i];
                mode_r[i] <= mode_nxt[i];
            end
            wr_r    <= wr_nxt;
            rd_r    <= rd_nxt;
            tgt_r   <= tgt_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Zero wait states, so hreadyout never stalls the master
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < NUM_TIMERS*NUM_CH; c++)
    begin : g_chan
        localparam int TM = c / NUM_CH;
        localparam int K  = c % NUM_CH;
        localparam int B  = K * CCE_CH_STRIDE;
        // Channel pairs 1/2 and 3/4 share each other's input
        localparam int PR = TM * NUM_CH + (K ^ 1);

        cce_chan u_chan (
            .hclk        (hclk),
            .hresetn     (hresetn),
            .polarity    (ccer_r[TM][B+CCE_POL_BIT]),
            .enable      (ccer_r[TM][B+CCE_EN_BIT]),
            .dir_sel     (mode_r[TM][B+CCE_SEL_LSB +: 2]),
            .cap_div     (mode_r[TM][B+CCE_DIV_LSB +: 2]),
            .oc_ref      (oc_ref[c]),
            .in_own      (timer_input[c]),
            .in_pair     (timer_input[PR]),
            .trig_in     (internal_trigger_input[TM]),
            .compare_out (chan_compare_output[c]),
            .compare_oe  (chan_compare_oe[c]),
            .capture     (chan_capture[c]),
            .trig_sensed (chan_trigger_sensed[c])
        );
    end

    // ------------------------------------------------------------
    // Checks on timer 1 channel 3, and on enable register writes and reads
    // ------------------------------------------------------------
    logic       pol3;
    logic       en3;
    logic [1:0] sel3;
    logic [1:0] div3;

    assign pol3 = ccer_r[0][9];
    assign en3  = ccer_r[0][8];
    assign sel3 = mode_r[0][9:8];
    assign div3 = mode_r[0][11:10];

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_own_input_rise: assert property (
        en3 && sel3 == 2'b01 && !pol3 && div3 == 2'b00 && $stable(ccer_r[0]) && $stable(mode_r[0])
        && $rose(timer_input[2])
        |=> chan_capture[2])
        else $error("Channel 3 missed a rising edge on its own input");

    chk_pair_input_fall: assert property (
        en3 && sel3 == 2'b10 && pol3 && div3 == 2'b00 && $stable(ccer_r[0]) && $stable(mode_r[0])
        && $fell(timer_input[3])
        |=> chan_capture[2])
        else $error("Channel 3 missed an inverted edge on its paired input");

    chk_trig_polarity: assert property (
        sel3 == 2'b11
        |=> chan_trigger_sensed[2] == ($past(internal_trigger_input[0]) ^ $past(pol3)))
        else $error("Trigger sense does not follow polarity");

    chk_out_sense: assert property (
        en3 && sel3 == 2'b00
        |=> chan_compare_oe[2] && chan_compare_output[2] == ($past(oc_ref[2]) ^ $past(pol3)))
        else $error("Compare output sense wrong");

    chk_disable_gate: assert property (
        !en3 |=> !chan_compare_oe[2] && !chan_capture[2])
        else $error("Disabled channel still active");

    chk_div_eight: assert property (
        chan_capture[2] && div3 == 2'b11 && en3
        |=> (!chan_capture[2] || div3 != 2'b11) [*8])
        else $error("Capture came sooner than every eighth edge");

    chk_ccer_layout: assert property (
        wr_r && tgt_r == 3'b100
        |=> ccer_r[0] == ($past(hwdata) & CCE_CCER_MASK))
        else $error("Enable register write not stored at its fields");

    chk_unused_zero: assert property (
        rd_r && tgt_r[CCE_DEC_VALID] && !tgt_r[CCE_DEC_MODE]
        |-> (hrdata & ~CCE_CCER_MASK) == 32'h0000_0000)
        else $error("Unused enable register bits read nonzero");

    chk_sel_locked: assert property (
        wr_r && tgt_r == 3'b110 && en3 |=> $stable(sel3))
        else $error("Direction select changed while enabled");

    cov_capture: cover property (en3 && sel3 != 2'b00 ##1 chan_capture[2]);
    cov_output:  cover property (chan_compare_oe[2] && pol3);
    cov_trigger: cover property (sel3 == 2'b11 ##1 chan_trigger_sensed[2]);
    cov_locked:  cover property (wr_r && tgt_r == 3'b110 && en3);

endmodule

`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import cce_pkg::*;
;
    // ----------
    // Signals
    // ----------
    localparam logic [31:0] E1 = CCE_T1_ENPOL_ADDR;
    localparam logic [31:0] E2 = CCE_T2_ENPOL_ADDR;
    localparam logic [31:0] M1 = CCE_TIM1_MODE_ADDR;
    localparam logic [31:0] M2 = CCE_TIM2_MODE_ADDR;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [7:0]  oc_ref;
    logic [7:0]  timer_input;
    logic [1:0]  internal_trigger_input;
    logic [7:0]  c_out;
    logic [7:0]  c_oe;
    logic [7:0]  c_cap;
    logic [7:0]  c_sense;
    int          bad_count;
    int          comparisons;
    int          cap_cnt;

    cce_top uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .oc_ref(oc_ref),
        .timer_input(timer_input), .internal_trigger_input(internal_trigger_input),
        .chan_compare_output(c_out), .chan_compare_oe(c_oe), .chan_capture(c_cap),
        .chan_trigger_sensed(c_sense)
    );

    always #10 hclk = ~hclk;

    // Counts capture pulses of timer 1 channel 3
    always @(posedge hclk)
        if (c_cap[2] === 1'h1)
            cap_cnt <= cap_cnt + 1;

    // ----------
    // Tasks
    // ----------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Bounded, so a stuck slave cannot hang the run
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'h1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        if (n == 50)
        begin
            bad_count++;
            test_done();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= 1'h1;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= 1'h0;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'h0;
        wait_rdy();
        check("hrdata", hrdata, exp);
    endtask

    task automatic out_chk(input logic [31:0] v1, input logic [31:0] v2);
        logic [31:0] v;
        logic [7:0]  en;
        logic [7:0]  out;
        wr(E1, v1);
        wr(E2, v2);
        repeat (2) @(posedge hclk);
        // Expected built after the waits, once a fresh oc_ref has landed
        for (int i = 0; i < 8; i++)
        begin
            v = (i < 4) ? v1 : v2;
            en[i] = v[4*(i%4)];
            out[i] = (oc_ref[i] ^ v[4*(i%4)+1]) & en[i];
        end
        check("compare_oe", 32'(c_oe), 32'(en));
        check("compare_out", 32'(c_out), 32'(out));
    endtask

    task automatic dir_chk(input logic [1:0] s, input logic p);
        wr(E1, {22'h0, p, 9'h0});
        wr(M1, {22'h0, s, 8'h0});
        for (int b = 0; b < 2; b++)
        begin
            timer_input[2] <= b[0] & (s == 2'h1);
            timer_input[3] <= b[0] & (s == 2'h2);
            internal_trigger_input[0] <= b[0] & (s == 2'h3);
            repeat (3) @(posedge hclk);
            check("trigger_sensed", 32'(c_sense[2]), 32'((s != 2'h0) & (b[0] ^ p)));
        end
    endtask

    task automatic cap_run(input logic p, input logic [1:0] dv, input logic e, input logic [1:0] s);
        int base;
        // Polarity set while disabled so the switch itself is no edge
        wr(E1, {22'h0, p, 9'h0});
        wr(M1, {20'h0, dv, s, 8'h0});
        wr(E1, {22'h0, p, e, 8'h0});
        repeat (2) @(posedge hclk);
        base = cap_cnt;
        for (int i = 0; i < 8; i++)
        begin
            timer_input[2] <= (s == 2'h1);
            timer_input[3] <= (s == 2'h2);
            repeat (3) @(posedge hclk);
            timer_input[2] <= 1'h0;
            timer_input[3] <= 1'h0;
            repeat (3) @(posedge hclk);
        end
        repeat (3) @(posedge hclk);
        check("capture_count", 32'(cap_cnt - base), e ? 32'(8 >> dv) : 32'h0);
    endtask

    // ----------
    // Tests
    // ----------
    initial
    begin
        hclk = 1'h0;
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        oc_ref = 8'hA5;
        timer_input = 8'h0;
        internal_trigger_input = 2'h0;
        bad_count = 0;
        comparisons = 0;
        cap_cnt = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rd_chk(E1, CCE_CCER_RESET);
        rd_chk(E2, CCE_CCER_RESET);
        rd_chk(M1, CCE_MODE_RESET);
        rd_chk(M2, CCE_MODE_RESET);
        check("hresp", 32'(hresp), 32'h0);
        $display("test reset done");
        wr(E1, 32'hFFFF_FFFF);
        rd_chk(E1, CCE_CCER_MASK);
        wr(E2, 32'hFFFF_FFFF);
        rd_chk(E2, CCE_CCER_MASK);
        wr(32'h4000_E030, 32'hFFFF_FFFF);
        rd_chk(32'h4000_E030, 32'h0);
        $display("test registers done");
        for (int r = 0; r < 2; r++)
        begin
            oc_ref <= r[0] ? 8'h5A : 8'hA5;
            out_chk(32'h0000_3333, 32'h0000_0000);
            out_chk(32'h0000_1111, 32'h0000_2222);
            out_chk(32'h0000_2121, 32'h0000_1212);
            out_chk(32'h0000_0000, 32'h0000_3333);
        end
        $display("test outputs done");
        for (int s = 0; s < 4; s++)
            for (int p = 0; p < 2; p++)
                dir_chk(2'(s), p[0]);
        $display("test direction done");
        cap_run(1'h0, 2'h0, 1'h1, 2'h1);
        cap_run(1'h1, 2'h0, 1'h1, 2'h1);
        cap_run(1'h0, 2'h1, 1'h1, 2'h1);
        cap_run(1'h0, 2'h2, 1'h1, 2'h1);
        cap_run(1'h0, 2'h3, 1'h1, 2'h1);
        cap_run(1'h1, 2'h0, 1'h0, 2'h1);
        cap_run(1'h1, 2'h0, 1'h1, 2'h2);
        $display("test capture done");
        wr(E1, 32'h0);
        wr(M1, 32'h0000_0100);
        wr(E1, 32'h0000_0100);
        wr(M1, 32'h0000_0E00);
        rd_chk(M1, 32'h0000_0D00);
        $display("test select lock done");
        test_done();
    end

    // Whole run needs well under 20000 cycles
    initial
    begin
        #1000000;
        bad_count++;
        test_done();
    end
endmodule

`default_nettype wire
